// ===== rtl/lux_timing_pkg.sv
// Constants shared by the light-sensor integration timing block.
// Assumes a 50 MHz system clock and a 32-bit Avalon-MM register port.
package lux_timing_pkg;

	// ----------------------------------------
	// Clock and oscillator timing
	// ----------------------------------------
	localparam int CLK_HZ = 50000000;
	localparam int OSC_FULL_HZ = 655000;
	localparam int OSC_HALF_HZ = 327000;
	// Divide ratios round down so the tick is never slower than nominal
	localparam int OSC_FULL_DIV = CLK_HZ / OSC_FULL_HZ;
	localparam int OSC_HALF_DIV = 2 * OSC_FULL_DIV;
	localparam logic [7:0] OSC_FULL_LAST = 8'(OSC_FULL_DIV - 1);
	localparam logic [7:0] OSC_HALF_LAST = 8'(OSC_HALF_DIV - 1);

	// ----------------------------------------
	// Register indices; byte address is four times the index
	// ----------------------------------------
	localparam logic [3:0] IDX_CMD = 4'h0;
	localparam logic [3:0] IDX_DATA_LSB = 4'h4;
	localparam logic [3:0] IDX_DATA_MSB = 4'h5;
	localparam logic [3:0] IDX_TIMER_LSB = 4'h6;
	localparam logic [3:0] IDX_TIMER_MSB = 4'h7;
	localparam logic [3:0] IDX_MODE = 4'h8;
	localparam logic [3:0] IDX_SYNC = 4'h9;
	localparam logic [3:0] IDX_STATUS = 4'hA;

	// ----------------------------------------
	// Command register fields and reset values
	// ----------------------------------------
	localparam int CMD_EXT_BIT = 5;
	localparam int CMD_RANGE_HI = 3;
	localparam int CMD_RANGE_LO = 2;
	localparam int CMD_WIDTH_HI = 1;
	localparam int CMD_WIDTH_LO = 0;
	localparam int SYNC_BIT = 0;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;

	// Diode selection modes
	typedef enum logic [1:0] {
		first_diode_mode = 2'h0,
		second_diode_mode = 2'h1,
		dual_diode_sequence_mode = 2'h3
	} mode_t;

endpackage

// ===== rtl/lux_osc_tick.sv
// Oscillator tick generator: a one-cycle enable at full or half rate.
// Assumes the range select comes from logic on the same clock.
`timescale 1ns/1ps
module lux_osc_tick
	import lux_timing_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic half_rate,
	output logic osc_tick
);

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	logic [7:0] div_q;
	logic [7:0] gap_q;
	logic half_seen_q;

	// Tick as an enable keeps all counting in the mclk domain (R15)
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			div_q <= 8'h00;
			osc_tick <= 1'b0;
		end else if (div_q >= (half_rate ? OSC_HALF_LAST : OSC_FULL_LAST)) begin // R1
			div_q <= 8'h00;
			osc_tick <= 1'b1;
		end else begin
			div_q <= div_q + 8'h01;
			osc_tick <= 1'b0;
		end
	end

	// Helper: cycles since last tick, and whether rate held across them
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			gap_q <= 8'h00;
			half_seen_q <= 1'b0;
		end else if (osc_tick) begin
			gap_q <= 8'h01;
			half_seen_q <= half_rate;
		end else begin
			gap_q <= gap_q + 8'h01;
			half_seen_q <= half_seen_q;
		end
	end

	a_tick_spacing: assert property (@(posedge mclk) disable iff (!rst_b) // R1
		osc_tick && $past(osc_tick, 300) == 1'b0 && $stable(half_rate) && half_seen_q == half_rate && gap_q != 8'h01
		|-> gap_q == (half_rate ? 8'(OSC_HALF_DIV) : 8'(OSC_FULL_DIV)))
		else $error("oscillator tick spacing wrong for range");

	a_tick_pulse: assert property (@(posedge mclk) disable iff (!rst_b) // R15
		osc_tick |=> !osc_tick)
		else $error("oscillator enable longer than one cycle");

endmodule

// ===== rtl/lux_timing_ctrl.sv
// Integration timing control for an integrating light-sensor converter.
// Assumes an Avalon-MM master on mclk and a converter pulse from another domain.
//
// Function
// (R1) The oscillator runs at half rate in the two lower ranges and full rate in the two upper ones.
// (R2) Command bit 5 selects external timing when set and internal timing when clear.
// (R3) Internal timing ends each integration after exactly 2^n oscillator cycles, n = 4, 8, 12 or 16 from bits 1:0.
// (R4) In a single-diode external mode one sync starts integration and the next stops it.
// (R5) Writing one to the sync bit ends the running integration and starts a new one at once; the block does so in external timing only.
// (R6) In dual-diode sequence mode syncs alternate diode one and diode two, two readings per three syncs.
// (R7) External timing uses the same oscillator and counts its cycles in a 16-bit counter.
// (R8) The host keeps each external integration under 65,535 oscillator periods.
// (R9) The host sets the external interval by the bus clocks it lets pass between syncs.
// (R10) The host should pick an interval that is a whole multiple of the mains period.
// (R11) In external timing the cycle count is published at the end of each integration, low byte first.
// (R12) The sensor result bytes are refreshed at the end of every integration.
// (R13) Command bits 3:2 select one of four ranges, zero lowest through three highest.
// (R14) Cycle counter and accumulator are cleared at the start of every integration.
// (R15) The oscillator is a clock enable derived from mclk, keeping one clock domain.
`timescale 1ns/1ps
module lux_timing_ctrl
	import lux_timing_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic light_pulse,
	output logic diode_sel,
	output logic integrating
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0] cmd_q;
	mode_t mode_q;
	logic [15:0] cyc_q;
	logic [15:0] acc_q;
	logic [15:0] data_q;
	logic [15:0] timer_q;
	logic cnt_ovf_q;
	logic pulse_meta_q;
	logic pulse_sync_q;
	logic pulse_last_q;
	logic pulse_rise;
	logic osc_tick;
	logic ext_mode;
	logic half_rate;
	logic [1:0] range_sel;
	logic [1:0] width_sel;
	logic [15:0] int_last;
	logic [3:0] reg_idx;
	logic bus_go;
	logic wr_go;
	logic sync_wr;
	logic int_end;
	logic int_start;
	logic [31:0] rd_d;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	assign ext_mode = cmd_q[CMD_EXT_BIT]; // R2
	assign range_sel = cmd_q[CMD_RANGE_HI:CMD_RANGE_LO]; // R13
	assign width_sel = cmd_q[CMD_WIDTH_HI:CMD_WIDTH_LO];
	// Lowest and second range run the oscillator at half rate
	assign half_rate = (range_sel < 2'h2); // R1

	// Last cycle index of an internal integration: 2^n - 1
	always_comb begin
		case (width_sel) // R3
			2'h0: int_last = 16'h000F;
			2'h1: int_last = 16'h00FF;
			2'h2: int_last = 16'h0FFF;
			default: int_last = 16'hFFFF;
		endcase
	end

	lux_osc_tick u_osc (
		.mclk(mclk),
		.rst_b(rst_b),
		.half_rate(half_rate),
		.osc_tick(osc_tick)
	);

	// ----------------------------------------
	// Converter pulse input
	// ----------------------------------------
	// Two flops before any logic; the edge detector reads the second and a third flop behind it
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pulse_meta_q <= 1'b0;
			pulse_sync_q <= 1'b0;
			pulse_last_q <= 1'b0;
		end else begin
			pulse_meta_q <= light_pulse;
			pulse_sync_q <= pulse_meta_q;
			pulse_last_q <= pulse_sync_q;
		end
	end
	assign pulse_rise = pulse_sync_q && !pulse_last_q;

	// ----------------------------------------
	// Avalon-MM slave
	// ----------------------------------------
	// Requests take effect only in the cycle waitrequest is seen low
	assign reg_idx = avs_address[5:2];
	assign bus_go = (avs_read || avs_write) && !avs_waitrequest;
	assign wr_go = avs_write && !avs_waitrequest;
	assign sync_wr = wr_go && reg_idx == IDX_SYNC && avs_writedata[SYNC_BIT];

	// One wait state: waitrequest drops the cycle after a request arrives
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
		end else if (bus_go) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !(avs_read || avs_write);
		end
	end

	// Read mux; unmapped indices read as zero
	always_comb begin
		rd_d = 32'h0000_0000;
		if (reg_idx == IDX_CMD) begin
			rd_d[7:0] = cmd_q;
		end else if (reg_idx == IDX_DATA_LSB) begin
			rd_d[7:0] = data_q[7:0];
		end else if (reg_idx == IDX_DATA_MSB) begin
			rd_d[7:0] = data_q[15:8];
		end else if (reg_idx == IDX_TIMER_LSB) begin
			rd_d[7:0] = timer_q[7:0]; // R11
		end else if (reg_idx == IDX_TIMER_MSB) begin
			rd_d[7:0] = timer_q[15:8]; // R11
		end else if (reg_idx == IDX_MODE) begin
			rd_d[1:0] = mode_q;
		end else if (reg_idx == IDX_STATUS) begin
			rd_d[2:0] = {cnt_ovf_q, diode_sel, integrating};
		end
	end

	// Read data are loaded as waitrequest falls, so they stand when sampled
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_d;
		end else begin
			avs_readdata <= avs_readdata;
		end
	end

	// Configuration writes
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_q <= CMD_RESET;
			mode_q <= first_diode_mode;
		end else if (wr_go && reg_idx == IDX_CMD) begin
			cmd_q <= avs_writedata[7:0];
		end else if (wr_go && reg_idx == IDX_MODE) begin
			mode_q <= mode_t'(avs_writedata[1:0]);
		end
	end

	// ----------------------------------------
	// Integration sequencing
	// ----------------------------------------
	// Internal timing ends on the last tick of 2^n; external on a sync
	assign int_end = ext_mode ? (sync_wr && integrating) // R4 R5
		: (osc_tick && cyc_q == int_last); // R3
	// A sync always begins a fresh integration in external timing
	assign int_start = ext_mode ? sync_wr : int_end; // R5

	// Integrating flag: internal timing free-runs, external waits for a sync
	// Switching into external timing stops the run, so the first sync only starts one
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			integrating <= 1'b0;
		end else if (wr_go && reg_idx == IDX_CMD && avs_writedata[CMD_EXT_BIT] && !ext_mode) begin
			integrating <= 1'b0; // R4
		end else if (!ext_mode) begin
			integrating <= 1'b1; // R2
		end else if (sync_wr) begin
			integrating <= 1'b1; // R4
		end
	end

	// Diode sequencing; dual mode swaps diode at each completed integration
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			diode_sel <= 1'b0;
		end else if (mode_q == second_diode_mode) begin
			diode_sel <= 1'b1;
		end else if (mode_q != dual_diode_sequence_mode) begin
			diode_sel <= 1'b0;
		end else if (int_end) begin
			diode_sel <= !diode_sel; // R6
		end
	end

	// Cycle counter: cleared at each start, saturates at 16 bits
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cyc_q <= 16'h0000;
			cnt_ovf_q <= 1'b0;
		end else if (int_start || (ext_mode && !integrating)) begin
			cyc_q <= 16'h0000; // R14
			cnt_ovf_q <= 1'b0;
		end else if (osc_tick && cyc_q == CNT_MAX) begin
			cyc_q <= CNT_MAX; // R7 R8
			cnt_ovf_q <= 1'b1;
		end else if (osc_tick) begin
			cyc_q <= cyc_q + 16'h0001; // R7 R11
		end
	end

	// Converter accumulator: counts converter pulses, saturating
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			acc_q <= 16'h0000;
		end else if (int_start) begin
			acc_q <= 16'h0000; // R14
		end else if (pulse_rise && integrating && acc_q != CNT_MAX) begin
			acc_q <= acc_q + 16'h0001;
		end
	end

	// Result publication at each integration end; timer only at external ones
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			data_q <= 16'h0000;
			timer_q <= 16'h0000;
		end else if (int_end) begin
			data_q <= acc_q; // R12
			timer_q <= ext_mode ? cyc_q : timer_q; // R11
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_range_rate: assert property (@(posedge mclk) disable iff (!rst_b) // R13
		half_rate == (cmd_q[CMD_RANGE_HI] == 1'b0))
		else $error("range field does not steer oscillator rate");

	a_internal_length: assert property (@(posedge mclk) disable iff (!rst_b) // R3
		!ext_mode && osc_tick && cyc_q == int_last ##1 !ext_mode [*8] |-> cyc_q == 16'h0000)
		else $error("internal integration did not wrap at 2^n");

	a_internal_ignores_sync: assert property (@(posedge mclk) disable iff (!rst_b) // R2
		!ext_mode && sync_wr && !int_end && !osc_tick |=> cyc_q == $past(cyc_q))
		else $error("sync disturbed internal timing");

	a_sync_restart: assert property (@(posedge mclk) disable iff (!rst_b) // R5
		ext_mode && sync_wr |=> integrating && cyc_q == 16'h0000 && acc_q == 16'h0000)
		else $error("sync did not restart integration");

	a_ext_timer: assert property (@(posedge mclk) disable iff (!rst_b) // R11
		ext_mode && int_end |=> timer_q == $past(cyc_q))
		else $error("timer count not published at integration end");

	a_data_refresh: assert property (@(posedge mclk) disable iff (!rst_b) // R12
		int_end |=> data_q == $past(acc_q))
		else $error("sensor result not refreshed");

	a_count_limit: assert property (@(posedge mclk) disable iff (!rst_b) // R7
		cyc_q == CNT_MAX && osc_tick && !int_start && integrating |=> cyc_q == CNT_MAX && cnt_ovf_q)
		else $error("cycle counter wrapped past 16 bits");

	a_count_hold: assert property (@(posedge mclk) disable iff (!rst_b) // R15
		!osc_tick && !int_start && integrating |=> cyc_q == $past(cyc_q))
		else $error("cycle counter moved without oscillator tick");

	a_dual_swap: assert property (@(posedge mclk) disable iff (!rst_b) // R6
		ext_mode && mode_q == dual_diode_sequence_mode && sync_wr && integrating
		|=> diode_sel != $past(diode_sel))
		else $error("dual sequence did not swap diode");

	a_bus_answer: assert property (@(posedge mclk) disable iff (!rst_b)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not after one wait state");

endmodule

// ===== dv/light_src.sv
// Light pulse source standing in for the converter front end.
// Assumes the bench enables it only while light is being measured.
`timescale 1ns/1ps
module light_src (
	input wire logic en,
	output logic light_pulse
);
	// ----------------------------------------
	// Pulse train
	// ----------------------------------------
	// Own 160 ns period, eight mclk periods, with every edge on an mclk falling edge; held low when disabled
	initial light_pulse = 1'b0;
	always begin
		#80;
		light_pulse = en ? ~light_pulse : 1'b0;
	end
endmodule

// ===== dv/test_lux_timing_ctrl.sv
// Self-checking bench for the integration timing controller.
// Assumes a 50 MHz mclk and the light source model beside the block.
`timescale 1ns/1ps
module test_lux_timing_ctrl
	import lux_timing_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] kind;
		logic [15:0] lo;
		logic [15:0] hi;
	} note_t;
	logic mclk;
	logic rst_b;
	logic [5:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic light_pulse;
	logic diode_sel;
	logic integrating;
	logic light_en;
	logic [31:0] seed;
	logic [7:0] held;
	logic [15:0] v;
	note_t notes[$];
	note_t e;
	int n_fail;
	int n_compared;

	lux_timing_ctrl dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .light_pulse(light_pulse), .diode_sel(diode_sel),
		.integrating(integrating));
	light_src src (.en(light_en), .light_pulse(light_pulse));

	// 50 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// One Avalon cycle; request held until waitrequest is sampled low
	task automatic bus(input logic wr_en, input logic [3:0] idx, input logic [31:0] wd);
		int i;
		@(posedge mclk);
		avs_address <= {idx, 2'h0};
		avs_read <= ~wr_en;
		avs_write <= wr_en;
		avs_writedata <= wd;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 20);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			n_fail++;
			results();
		end
	endtask

	// Upper bytes are random, since only the low byte should matter
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		seed = xs(seed);
		bus(1'b1, idx, {seed[31:8], d});
	endtask

	// Kind 0 single byte, 1 low half, 2 high half of a 16-bit value
	task automatic rd(input logic [3:0] idx, input logic [1:0] k, input int lo, input int hi);
		notes.push_back('{k, 16'(lo), 16'(hi)});
		bus(1'b0, idx, 32'h0);
	endtask

	task automatic rd16(input logic [3:0] idx, input int lo, input int hi);
		rd(idx, 2'h1, lo, hi);
		rd(4'(idx + 1), 2'h2, lo, hi);
	endtask

	// Read monitor: oldest note against the data taken at the sampling edge
	always @(posedge mclk) begin
		if (avs_read && !avs_waitrequest) begin
			e = notes.pop_front();
			check(32'(avs_readdata[31:8]), 32'h0);
			if (e.kind == 2'h1) held = avs_readdata[7:0];
			else begin
				v = (e.kind == 2'h2) ? {avs_readdata[7:0], held} : {8'h00, avs_readdata[7:0]};
				check(32'((v >= e.lo && v <= e.hi) ? e.lo : v), 32'(e.lo));
			end
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin : main
		int div;
		int x;
		int t;
		logic [7:0] icmd [3] = '{8'h0C, 8'h00, 8'h09};
		rst_b = 1'b0;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		light_en = 1'b0;
		seed = 32'hA4A951B0;
		n_fail = 0;
		n_compared = 0;
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		light_en <= 1'b1;
		// Reset state and an unmapped index
		rd(IDX_CMD, 2'h0, 0, 0);
		rd(IDX_STATUS, 2'h0, 1, 1);
		rd(4'hB, 2'h0, 0, 0);
		$display("test reset done");
		// Internal timing; two full periods pass so one clean window is published
		for (int k = 0; k < 3; k++) begin
			div = icmd[k][3] ? OSC_FULL_DIV : OSC_HALF_DIV;
			t = (1 << (4 + 4 * icmd[k][1:0])) * div;
			wr(IDX_CMD, icmd[k]);
			wr(IDX_SYNC, 8'h01);
			repeat (2 * t + 200) @(posedge mclk);
			rd16(IDX_DATA_LSB, t / 8 - 2, t / 8 + 2);
		end
		rd(IDX_CMD, 2'h0, 9, 9);
		$display("test internal done");
		// External timing over all four ranges; intervals stay far below overflow
		for (int r = 0; r < 4; r++) begin
			div = r[1] ? OSC_FULL_DIV : OSC_HALF_DIV;
			wr(IDX_CMD, 8'h20 | 8'(r << 2));
			wr(IDX_SYNC, 8'h01);
			seed = xs(seed);
			x = 1000 + int'(seed[9:0]);
			repeat (x) @(posedge mclk);
			wr(IDX_SYNC, 8'h01);
			rd16(IDX_TIMER_LSB, (x + 3) / div - 2, (x + 3) / div + 2);
			rd16(IDX_DATA_LSB, (x + 3) / 8 - 3, (x + 3) / 8 + 3);
		end
		$display("test external done");
		// Second reset gives a known diode before the dual sequence
		rst_b <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		rd(IDX_STATUS, 2'h0, 1, 1);
		wr(IDX_MODE, 8'h03);
		wr(IDX_CMD, 8'h20);
		for (int s = 0; s < 3; s++) begin
			wr(IDX_SYNC, 8'h01);
			rd(IDX_STATUS, 2'h0, (s == 1) ? 3 : 1, (s == 1) ? 3 : 1);
			check(32'({diode_sel, integrating}), (s == 1) ? 32'h3 : 32'h1);
		end
		$display("test dual done");
		light_en <= 1'b0;
		results();
	end
endmodule
